// ---- rtl/mtd_alu_map.svh ----
`ifndef MTD_ALU_MAP_SVH
`define MTD_ALU_MAP_SVH
`define MTD_ACC_W        40
`define MTD_HALF_W       16
`define MTD_PROD_W       32
`define MTD_SHAMT_W      6
`define MTD_WIDE_SHIFT   16
`define MTD_HALF_SHIFT   1
`define MTD_OV_RESET     1'b0
`define MTD_IMM_EXCLUDED 40'h00_0000_0001
`endif

// ---- rtl/mtd_alu_pkg.sv ----
package mtd_alu_pkg;
  typedef enum logic [4:0] {
    MTD_OP_NOP      = 5'h00,
    MTD_OP_MAC      = 5'h01,
    MTD_OP_MSU      = 5'h02,
    MTD_OP_MAC_SU   = 5'h03,
    MTD_OP_MAC_UU   = 5'h04,
    MTD_OP_MAC_SH1  = 5'h05,
    MTD_OP_MAC_SH16 = 5'h06,
    MTD_OP_MUL      = 5'h07,
    MTD_OP_ADD      = 5'h08,
    MTD_OP_ADDI     = 5'h09,
    MTD_OP_SUB      = 5'h0A,
    MTD_OP_SUBI     = 5'h0B,
    MTD_OP_SRA      = 5'h0C,
    MTD_OP_SRAI     = 5'h0D,
    MTD_OP_SRL      = 5'h0E,
    MTD_OP_SRLI     = 5'h0F,
    MTD_OP_SLL      = 5'h10,
    MTD_OP_SLLI     = 5'h11
  } mtd_op_t;

  typedef struct packed {
    logic        valid;
    mtd_op_t     op;
    logic [39:0] src_a;
    logic [39:0] src_b;
    logic [15:0] upper_half_operand;
    logic [15:0] upper_half_operand2;
    logic [15:0] lower_half_operand;
    logic [15:0] lower_half_operand2;
    logic [39:0] imm;
    logic [2:0]  dest;
    logic        ldst_req;
  } mtd_req_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  dest;
    logic [39:0] data;
    logic        ldst_ok;
  } mtd_res_t;
endpackage

// ---- rtl/mtd_alu.sv ----
// What this block does
// RQ1: flagged overflow sets the overflow flag
// RQ2: overflow flag is sticky, cleared only by reset
// RQ3: signed high times unsigned low, accumulate
// RQ4: unsigned low times unsigned low, accumulate
// RQ5: accumulator halved then signed product added
// RQ6: accumulator shifted sixteen, overflow untouched
// RQ7: add immediate, flag overflow, one excluded
// RQ8: subtract immediate, flag overflow, one excluded
// RQ9: right shifts by register or immediate
// RQ10: left shift zero fill, flag untouched
// RQ11: register forms allow concurrent load/store
// RQ12: mac, msu, add, sub flag; multiply not
// RQ13: full 32-bit products extended, one cycle
`include "mtd_alu_map.svh"
module mtd_alu
  import mtd_alu_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     srst,
  input  wire mtd_req_t req,
  output mtd_res_t      res,
  output logic          overflow_flag,
  output logic          illegal_op
);
  localparam int AW = `MTD_ACC_W;

  mtd_res_t         res_r;
  mtd_res_t         res_nxt;
  logic             ov_r;
  logic             ov_nxt;
  logic             ill_r;
  logic             ill_nxt;
  logic             ov_set;

  // signed overflow of a 40-bit add
  function automatic logic add_ov(input logic [39:0] a, input logic [39:0] b,
                                  input logic [39:0] s);
    add_ov = (a[39] == b[39]) && (s[39] != a[39]);
  endfunction

  function automatic logic sub_ov(input logic [39:0] a, input logic [39:0] b,
                                  input logic [39:0] d);
    sub_ov = (a[39] != b[39]) && (d[39] != a[39]);
  endfunction

  // immediate forms of the dyadic group
  function automatic logic op_imm_form(input mtd_op_t op);
    unique case (op)
      MTD_OP_ADDI: op_imm_form = 1'b1;
      MTD_OP_SUBI: op_imm_form = 1'b1;
      MTD_OP_SRAI: op_imm_form = 1'b1;
      MTD_OP_SRLI: op_imm_form = 1'b1;
      MTD_OP_SLLI: op_imm_form = 1'b1;
      default: op_imm_form = 1'b0;
    endcase
  endfunction

  // only defined operations write a result back
  function automatic logic op_writes_back(input mtd_op_t op);
    unique case (op)
      MTD_OP_MAC, MTD_OP_MSU, MTD_OP_MAC_SU, MTD_OP_MAC_UU: op_writes_back = 1'b1;
      MTD_OP_MAC_SH1, MTD_OP_MAC_SH16, MTD_OP_MUL: op_writes_back = 1'b1;
      MTD_OP_ADD, MTD_OP_ADDI, MTD_OP_SUB, MTD_OP_SUBI: op_writes_back = 1'b1;
      MTD_OP_SRA, MTD_OP_SRAI, MTD_OP_SRL, MTD_OP_SRLI: op_writes_back = 1'b1;
      MTD_OP_SLL, MTD_OP_SLLI: op_writes_back = 1'b1;
      default: op_writes_back = 1'b0;
    endcase
  endfunction

  // add/sub immediate of one, and any immediate form with load/store, are refused
  function automatic logic op_refused(input mtd_req_t q);
    logic one;
    one = (q.imm == `MTD_IMM_EXCLUDED);
    unique case (q.op)
      MTD_OP_ADDI: op_refused = one || q.ldst_req;
      MTD_OP_SUBI: op_refused = one || q.ldst_req;
      MTD_OP_SRAI: op_refused = q.ldst_req;
      MTD_OP_SRLI: op_refused = q.ldst_req;
      MTD_OP_SLLI: op_refused = q.ldst_req;
      default: op_refused = 1'b0;
    endcase
  endfunction

  // extend a product to the accumulator width, signed or not
  function automatic logic [39:0] widen(input logic [32:0] p, input logic sgn);
    widen = sgn ? {{7{p[32]}}, p} : {7'h00, p};
  endfunction

  // shift amount from a low half or immediate, saturated to the width
  function automatic logic [5:0] shamt(input logic [15:0] v);
    shamt = (v > 16'(AW)) ? 6'(AW) : v[5:0];
  endfunction

  logic signed [31:0] p_ss;
  logic signed [32:0] p_su;
  logic        [31:0] p_uu;
  logic        [39:0] prod_ss;
  logic        [39:0] prod_su;
  logic        [39:0] prod_uu;
  logic        [39:0] acc_sh1;
  logic        [39:0] acc_sh16;
  logic        [15:0] amt_src;
  logic        [5:0]  amt;
  logic        [39:0] opnd;
  logic        [39:0] sum;
  logic               ovf;
  logic               flagged;
  logic               is_imm;

  always_comb begin
    // full products extended to the accumulator width
    p_ss = $signed(req.upper_half_operand) * $signed(req.upper_half_operand2); // RQ13
    p_su = $signed(req.upper_half_operand) * $signed({1'b0, req.lower_half_operand}); // RQ3
    p_uu = req.lower_half_operand * req.lower_half_operand2; // RQ4
    prod_ss = widen({p_ss[31], p_ss}, 1'b1); // RQ13
    prod_su = widen(p_su, 1'b1);
    prod_uu = widen({1'b0, p_uu}, 1'b0);
    acc_sh1 = $unsigned($signed(req.src_a) >>> `MTD_HALF_SHIFT); // RQ5
    acc_sh16 = $unsigned($signed(req.src_a) >>> `MTD_WIDE_SHIFT); // RQ6
    is_imm = op_imm_form(req.op);
    amt_src = is_imm ? req.imm[15:0] : req.lower_half_operand;
    amt = shamt(amt_src);
    opnd = 40'h00_0000_0000;
    sum = 40'h00_0000_0000;
    ovf = 1'b0;
    flagged = 1'b0;
    ill_nxt = 1'b0;
    unique case (req.op)
      MTD_OP_MAC: begin
        opnd = prod_ss;
        sum = req.src_a + opnd;
        ovf = add_ov(req.src_a, opnd, sum);
        flagged = 1'b1; // RQ12
      end
      MTD_OP_MSU: begin
        opnd = prod_ss;
        sum = req.src_a - opnd;
        ovf = sub_ov(req.src_a, opnd, sum);
        flagged = 1'b1; // RQ12
      end
      MTD_OP_MAC_SU: begin
        opnd = prod_su;
        sum = req.src_a + opnd; // RQ3
        ovf = add_ov(req.src_a, opnd, sum);
        flagged = 1'b1;
      end
      MTD_OP_MAC_UU: begin
        opnd = prod_uu;
        sum = req.src_a + opnd; // RQ4
        ovf = add_ov(req.src_a, opnd, sum);
        flagged = 1'b1;
      end
      MTD_OP_MAC_SH1: begin
        opnd = prod_ss;
        sum = acc_sh1 + opnd; // RQ5
        ovf = add_ov(acc_sh1, opnd, sum);
        flagged = 1'b1;
      end
      MTD_OP_MAC_SH16: begin
        sum = acc_sh16 + prod_ss; // RQ6
      end
      MTD_OP_MUL: begin
        sum = prod_ss; // RQ12
      end
      MTD_OP_ADD: begin
        sum = req.src_a + req.src_b;
        ovf = add_ov(req.src_a, req.src_b, sum);
        flagged = 1'b1; // RQ12
      end
      MTD_OP_SUB: begin
        sum = req.src_a - req.src_b;
        ovf = sub_ov(req.src_a, req.src_b, sum);
        flagged = 1'b1; // RQ12
      end
      MTD_OP_ADDI: begin
        sum = req.src_a + req.imm; // RQ7
        ovf = add_ov(req.src_a, req.imm, sum);
        flagged = 1'b1;
      end
      MTD_OP_SUBI: begin
        sum = req.src_a - req.imm; // RQ8
        ovf = sub_ov(req.src_a, req.imm, sum);
        flagged = 1'b1;
      end
      MTD_OP_SRA, MTD_OP_SRAI: begin
        sum = $unsigned($signed(req.src_a) >>> amt); // RQ9
      end
      MTD_OP_SRL, MTD_OP_SRLI: begin
        sum = req.src_a >> amt; // RQ9
      end
      MTD_OP_SLL, MTD_OP_SLLI: begin
        sum = req.src_a << amt; // RQ10
      end
      default: begin
        sum = 40'h00_0000_0000;
      end
    endcase
    // immediate forms refuse a concurrent load/store
    ill_nxt = req.valid && op_refused(req); // RQ7 RQ8 RQ11
    // excluded or refused requests do not write back
    res_nxt.valid = req.valid && !ill_nxt && op_writes_back(req.op);
    res_nxt.dest = req.dest;
    res_nxt.data = sum; // RQ13
    res_nxt.ldst_ok = req.valid && req.ldst_req && !is_imm; // RQ11
  end

  // result and refusal registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      res_r <= '0;
      ill_r <= 1'b0;
    end else begin
      res_r <= res_nxt;
      ill_r <= ill_nxt;
    end
  end

  // overflow group: sticky, only reset clears, reset wins over a set in the same cycle
  always_comb begin
    ov_set = res_nxt.valid && flagged && ovf; // RQ1
    ov_nxt = ov_r | ov_set; // RQ2
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ov_r <= `MTD_OV_RESET;
    end else begin
      ov_r <= ov_nxt;
    end
  end

  assign res = res_r;
  assign overflow_flag = ov_r;
  assign illegal_op = ill_r;
endmodule // mtd_alu

// ---- test/mtd_alu_monitor.sv ----
module mtd_alu_monitor
  import mtd_alu_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     srst,
  input wire mtd_req_t req,
  input wire mtd_res_t res,
  input wire logic     overflow_flag,
  input wire logic     illegal_op
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] prod;
  assign prod = $signed(req.upper_half_operand) * $signed(req.upper_half_operand2);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sticky_flag_a: assert property (overflow_flag |=> overflow_flag)
    else $error("flag cleared");
  mul_keep_a: assert property (req.valid && req.op == MTD_OP_MUL |=> $stable(overflow_flag))
    else $error("mul flag");
  wide_keep_a: assert property (req.valid && req.op == MTD_OP_MAC_SH16 |=>
    $stable(overflow_flag)) else $error("wide flag");
  shift_keep_a: assert property (req.valid && req.op inside {[MTD_OP_SRA:MTD_OP_SLLI]} |=>
    $stable(overflow_flag)) else $error("shift flag");
  one_refused_a: assert property (req.valid && req.op inside {MTD_OP_ADDI, MTD_OP_SUBI} &&
    req.imm == 40'h1 |=> illegal_op && !res.valid) else $error("imm one");
  imm_ldst_a: assert property (req.valid && req.ldst_req && req.op[0] && req.op >= MTD_OP_ADDI
    |=> illegal_op && !res.valid) else $error("imm ldst");
  reg_ldst_a: assert property (req.valid && req.ldst_req && req.op inside {MTD_OP_MAC, MTD_OP_SUB,
    MTD_OP_SRA} |=> res.valid && res.ldst_ok) else $error("reg ldst");
  mac_sum_a: assert property (req.valid && req.op == MTD_OP_MAC |=>
    res.data == $past(req.src_a) + 40'($past(prod))) else $error("mac sum");
  sll_shift_a: assert property (req.valid && req.op == MTD_OP_SLL && req.lower_half_operand < 16'h28
    |=> res.data == $past(req.src_a) << $past(req.lower_half_operand)) else $error("sll");
  cover property (req.valid && req.op == MTD_OP_MAC_UU);
  cover property ($rose(overflow_flag));
  cover property (illegal_op);
endmodule // mtd_alu_monitor

// ---- test/mtd_alu_rf.sv ----
module mtd_alu_rf
  import mtd_alu_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     srst,
  input wire mtd_res_t res
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] regs [8];
  always_ff @(posedge core_clk) begin
    if (srst) regs <= '{default: '0};
    else if (res.valid) regs[res.dest] <= res.data;
  end
endmodule // mtd_alu_rf

// ---- test/mtd_alu_test.sv ----
module mtd_alu_test import mtd_alu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0;
  logic        srst = 1;
  logic        overflow_flag;
  logic        illegal_op;
  logic        ov_m = 0;
  logic [31:0] lf = 32'h0001_62C9;
  mtd_req_t    req = '0;
  mtd_res_t    res;
  int          n_errors = 0;
  int          num_checks = 0;
  always #4 core_clk = ~core_clk;
  mtd_alu uut (.core_clk(core_clk), .srst(srst), .req(req), .res(res),
    .overflow_flag(overflow_flag), .illegal_op(illegal_op));
  mtd_alu_rf rf (.core_clk(core_clk), .srst(srst), .res(res));
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic [40:0] ref_op(mtd_req_t q);
    longint a, hh, s, sh;
    logic f;
    a = longint'($signed(q.src_a));
    hh = $signed(q.upper_half_operand) * $signed(q.upper_half_operand2);
    sh = q.op[0] ? longint'(q.imm[15:0]) : longint'(q.lower_half_operand);
    if (sh > 40) sh = 40;
    f = 1;
    case (q.op)
      MTD_OP_MAC: s = a + hh;
      MTD_OP_MSU: s = a - hh;
      MTD_OP_MAC_SU: s = a + $signed(q.upper_half_operand) * longint'(q.lower_half_operand);
      MTD_OP_MAC_UU: s = a + longint'(q.lower_half_operand) * longint'(q.lower_half_operand2);
      MTD_OP_MAC_SH1: s = (a >>> 1) + hh;
      MTD_OP_MAC_SH16: begin s = (a >>> 16) + hh; f = 0; end
      MTD_OP_MUL: begin s = hh; f = 0; end
      MTD_OP_ADD: s = a + longint'($signed(q.src_b));
      MTD_OP_SUB: s = a - longint'($signed(q.src_b));
      MTD_OP_ADDI: s = a + longint'($signed(q.imm));
      MTD_OP_SUBI: s = a - longint'($signed(q.imm));
      MTD_OP_SRA, MTD_OP_SRAI: begin s = a >>> sh; f = 0; end
      MTD_OP_SRL, MTD_OP_SRLI: begin s = longint'(q.src_a) >> sh; f = 0; end
      default: begin s = longint'(q.src_a) << sh; f = 0; end
    endcase
    return {f && (s > 64'sh7F_FFFF_FFFF || s < -64'sh80_0000_0000), s[39:0]};
  endfunction
  task automatic chk(string nm, logic [43:0] e, logic [43:0] s);
    num_checks++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  task automatic run(mtd_req_t q);
    logic [40:0] e;
    logic bad;
    @(posedge core_clk);
    q.valid = 1;
    q.src_a = rf.regs[q.dest];
    bad = (q.op inside {MTD_OP_ADDI, MTD_OP_SUBI} && q.imm == 40'h1) ||
      (q.op[0] && q.op >= MTD_OP_ADDI && q.ldst_req);
    e = ref_op(q);
    req <= q;
    @(posedge core_clk);
    req.valid <= 0;
    #1;
    ov_m = ov_m | (e[40] & !bad);
    chk("status", 44'({!bad, bad, ov_m}), 44'({res.valid, illegal_op, overflow_flag}));
    if (!bad) chk("result", {q.dest, e[39:0], q.ldst_req}, {res.dest, res.data, res.ldst_ok});
    @(posedge core_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
  initial begin
    mtd_req_t q;
    repeat (3) @(posedge core_clk);
    srst <= 0;
    for (int i = 0; i < 342; i++) begin
      q = '0;
      q.op = mtd_op_t'(5'(i % 17 + 1));
      {q.upper_half_operand, q.upper_half_operand2, q.lower_half_operand, q.lower_half_operand2} = {rnd(), rnd()};
      q.src_b = 40'({rnd(), rnd()});
      q.imm = lf[7] ? 40'(rnd() % 44) : 40'({rnd(), rnd()});
      if (lf[9]) q.lower_half_operand = 16'(rnd() % 44);
      q.dest = lf[2:0];
      q.ldst_req = lf[4];
      if (i > 339) begin
        q.op = i[0] ? MTD_OP_SUBI : MTD_OP_ADDI;
        q.imm = 40'h1;
      end
      run(q);
    end
    complete_run();
  end
endmodule // mtd_alu_test
bind mtd_alu mtd_alu_monitor mon (.core_clk(core_clk), .srst(srst), .req(req), .res(res),
  .overflow_flag(overflow_flag), .illegal_op(illegal_op));
